// ---- verilog/charger_option_low_byte_ctrl.sv ----
// Purpose: Lower control byte of the charger option register and its timed actions
// Assumes: Analog levels arrive asynchronously; register access decoded upstream
// Notes: Upper byte bits are stored and read back only
// Functional notes
// R01: Polarity 0: output low while input above threshold; default.
// R02: Polarity 1: output low while input below threshold.
// R03: Deglitch applies only to falling output edges; rising passes at once.
// R04: Filter code 00 disables comparator; 10 gives 2 ms, 11 gives 5 s.
// R05: Filter code 01 gives 1 us deglitch and is the reset value.
// R06: Force bit set: comparator trip turns both converter switches off.
// R07: Supply good goes low on forced off; bit clear by default.
// R08: Discharge bit set drives battery negative sense discharge for 140 ms.
// R09: Discharge bit clears itself when the 140 ms interval ends.
// R10: Wakeup bit with low battery starts 128 mA charge up to 30 minutes.
// R11: Battery rising above minimum stops wakeup charge and clears the bit.
// R12: Threshold select 0 picks 2.3 V, 1 picks 1.2 V; default 0.
// R13: Timers run off a free-running time base and restart when newly enabled.

`timescale 1ns/1ps
`default_nettype none

module charger_option_low_byte_ctrl
  import charger_ctrl_pkg::*;
#(
  parameter int unsigned DEG_LONG_TICKS = DEG_LONG_MS,
  parameter int unsigned DISCHARGE_TICKS = DISCHARGE_MS,
  parameter int unsigned WAKEUP_TICKS = WAKEUP_MS,
  parameter int unsigned US_CYCLES = TICK_US_CYCLES,
  parameter int unsigned MS_US = US_PER_MS
) (
  input wire logic clk,
  input wire logic srst,
  input wire reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  input wire logic comparator_input_above,
  input wire logic battery_below_min,
  input wire logic converter_enable,
  input wire logic supply_good_source,
  output logic comparator_output,
  output logic comparator_threshold_select,
  output logic input_side_switch_on,
  output logic output_side_switch_on,
  output logic supply_good_indicator,
  output logic battery_sense_negative_discharge,
  output logic wakeup_charge_128ma
);

  initial begin
    if (US_CYCLES < 2 || MS_US < 2 || WAKEUP_TICKS >= (1 << TMR_W)) begin
      $error("charger_option_low_byte_ctrl timing parameters out of range");
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cmp_sync_ff;
  logic [1:0] bat_sync_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_sync_ff <= 2'h0;
      bat_sync_ff <= 2'h0;
    end else begin
      cmp_sync_ff <= {cmp_sync_ff[0], comparator_input_above};
      bat_sync_ff <= {bat_sync_ff[0], battery_below_min};
    end
  end

  // ----------------------------------------------------------------
  // Free-running time base
  // ----------------------------------------------------------------
  logic [15:0] us_cnt_ff;
  logic [15:0] ms_cnt_ff;
  logic us_tick_ff;
  logic ms_tick_ff;

  always_ff @(posedge clk) begin // R13
    if (srst) begin
      us_cnt_ff <= 16'h0000;
      us_tick_ff <= 1'b0;
    end else if (us_cnt_ff == 16'(US_CYCLES - 1)) begin
      us_cnt_ff <= 16'h0000;
      us_tick_ff <= 1'b1;
    end else begin
      us_cnt_ff <= us_cnt_ff + 16'h0001;
      us_tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ms_cnt_ff <= 16'h0000;
      ms_tick_ff <= 1'b0;
    end else if (us_tick_ff && ms_cnt_ff == 16'(MS_US - 1)) begin
      ms_cnt_ff <= 16'h0000;
      ms_tick_ff <= 1'b1;
    end else begin
      if (us_tick_ff) begin
        ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      end
      ms_tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [15:0] ctrl_ff;
  logic host_wr;
  logic discharge_expired;
  logic wakeup_clear;
  filter_sel_t filter_sel;

  assign host_wr = reg_req.wr && (reg_req.addr == CTRL_B_OFFSET);
  assign filter_sel = filter_sel_t'(ctrl_ff[BIT_FILTER_HI:BIT_FILTER_LO]);

  // Host write wins over a self-clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= CTRL_B_RESET; // R05
    end else if (host_wr) begin
      ctrl_ff <= reg_req.wdata;
    end else begin
      if (discharge_expired) begin
        ctrl_ff[BIT_DISCHARGE] <= 1'b0; // R09
      end
      if (wakeup_clear) begin
        ctrl_ff[BIT_WAKEUP] <= 1'b0; // R11
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd && reg_req.addr == CTRL_B_OFFSET) begin
      reg_rdata <= ctrl_ff;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Independent comparator
  // ----------------------------------------------------------------
  logic cmp_enabled;
  logic raw_high;
  logic deg_expired;
  logic deg_tick;
  logic [TMR_W-1:0] deg_limit;
  logic cmp_prev_ff;
  logic trip;

  assign cmp_enabled = (filter_sel != FILT_OFF); // R04
  // Polarity 0 inverts the above-threshold level
  assign raw_high = ctrl_ff[BIT_POLARITY] ? cmp_sync_ff[1] : !cmp_sync_ff[1]; // R01 R02
  assign deg_tick = (filter_sel == FILT_1US) ? us_tick_ff : ms_tick_ff;

  always_comb begin
    case (filter_sel)
      FILT_1US: deg_limit = TMR_W'(DEG_SHORT_US); // R05
      FILT_2MS: deg_limit = TMR_W'(DEG_MID_MS); // R04
      FILT_5S: deg_limit = TMR_W'(DEG_LONG_TICKS); // R04
      default: deg_limit = TMR_W'(1);
    endcase
  end

  tick_timer #(.W(TMR_W)) u_deg_timer (
    .clk(clk),
    .srst(srst),
    .run(cmp_enabled && !raw_high && comparator_output),
    .tick(deg_tick),
    .limit(deg_limit),
    .expired(deg_expired)
  );

  // Disabled comparator parks its output high so nothing trips
  always_ff @(posedge clk) begin
    if (srst) begin
      comparator_output <= 1'b1;
    end else if (!cmp_enabled || raw_high) begin
      comparator_output <= 1'b1; // R03
    end else if (deg_expired) begin
      comparator_output <= 1'b0; // R03
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_prev_ff <= 1'b1;
      comparator_threshold_select <= 1'b0;
    end else begin
      cmp_prev_ff <= comparator_output;
      comparator_threshold_select <= ctrl_ff[BIT_THRESH_SEL]; // R12
    end
  end

  assign trip = cmp_prev_ff && !comparator_output;

  // ----------------------------------------------------------------
  // Forced path off
  // ----------------------------------------------------------------
  logic path_off_ff;

  // Latched until software drops the force bit; a trip once the bit is clear does not set
  always_ff @(posedge clk) begin
    if (srst) begin
      path_off_ff <= 1'b0;
    end else if (ctrl_ff[BIT_FORCE_OFF] && trip) begin
      path_off_ff <= 1'b1; // R06
    end else if (!ctrl_ff[BIT_FORCE_OFF]) begin
      path_off_ff <= 1'b0; // R07
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      input_side_switch_on <= 1'b0;
      output_side_switch_on <= 1'b0;
      supply_good_indicator <= 1'b0;
    end else begin
      input_side_switch_on <= converter_enable && !path_off_ff; // R06
      output_side_switch_on <= converter_enable && !path_off_ff; // R06
      supply_good_indicator <= supply_good_source && !path_off_ff; // R07
    end
  end

  // ----------------------------------------------------------------
  // Storage discharge
  // ----------------------------------------------------------------
  tick_timer #(.W(TMR_W)) u_dchg_timer (
    .clk(clk),
    .srst(srst),
    .run(ctrl_ff[BIT_DISCHARGE]), // R13
    .tick(ms_tick_ff),
    .limit(TMR_W'(DISCHARGE_TICKS)),
    .expired(discharge_expired)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      battery_sense_negative_discharge <= 1'b0;
    end else begin
      battery_sense_negative_discharge <= ctrl_ff[BIT_DISCHARGE] && !discharge_expired; // R08
    end
  end

  // ----------------------------------------------------------------
  // Auto wakeup charge
  // ----------------------------------------------------------------
  wakeup_state_t wk_state_ff;
  wakeup_state_t nxt_wk_state;
  logic wk_expired;

  always_comb begin
    nxt_wk_state = wk_state_ff;
    wakeup_clear = 1'b0;
    case (wk_state_ff)
      WK_IDLE: begin
        if (ctrl_ff[BIT_WAKEUP] && bat_sync_ff[1]) begin
          nxt_wk_state = WK_CHARGE; // R10
        end
      end
      WK_CHARGE: begin
        if (!bat_sync_ff[1]) begin
          nxt_wk_state = WK_IDLE;
          wakeup_clear = 1'b1; // R11
        end else if (!ctrl_ff[BIT_WAKEUP]) begin
          nxt_wk_state = WK_IDLE;
        end else if (wk_expired) begin
          nxt_wk_state = WK_DONE; // R10
        end
      end
      WK_DONE: begin
        // Stay parked so a timed-out charge is not retried endlessly
        if (!ctrl_ff[BIT_WAKEUP] || !bat_sync_ff[1]) begin
          nxt_wk_state = WK_IDLE;
        end
      end
      default: nxt_wk_state = WK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wk_state_ff <= WK_IDLE;
    end else begin
      wk_state_ff <= nxt_wk_state;
    end
  end

  tick_timer #(.W(TMR_W)) u_wake_timer (
    .clk(clk),
    .srst(srst),
    .run(wk_state_ff == WK_CHARGE), // R13
    .tick(ms_tick_ff),
    .limit(TMR_W'(WAKEUP_TICKS)),
    .expired(wk_expired)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      wakeup_charge_128ma <= 1'b0;
    end else begin
      wakeup_charge_128ma <= (nxt_wk_state == WK_CHARGE); // R10
    end
  end

endmodule : charger_option_low_byte_ctrl

`default_nettype wire

// ---- verilog/charger_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the charger option low byte control block
// Assumes: 40 MHz core clock, register word already decoded by the serial bus engine
// Notes: Timer lengths are given in their own units and converted to ticks here

package charger_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_US_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned US_PER_MS = 1000;

  // Deglitch, discharge and wakeup times in their printed units
  localparam int unsigned DEG_SHORT_US = 1;
  localparam int unsigned DEG_MID_MS = 2;
  localparam int unsigned DEG_LONG_MS = 5000;
  localparam int unsigned DISCHARGE_MS = 140;
  localparam int unsigned WAKEUP_MIN = 30;
  localparam int unsigned WAKEUP_MS = WAKEUP_MIN * 60 * 1000;
  localparam int unsigned TMR_W = 21;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_B_OFFSET = 8'h30;
  localparam logic [15:0] CTRL_B_RESET = 16'h0211;
  localparam int unsigned BIT_THRESH_SEL = 7;
  localparam int unsigned BIT_POLARITY = 6;
  localparam int unsigned BIT_FILTER_HI = 5;
  localparam int unsigned BIT_FILTER_LO = 4;
  localparam int unsigned BIT_FORCE_OFF = 3;
  localparam int unsigned BIT_DISCHARGE = 1;
  localparam int unsigned BIT_WAKEUP = 0;

  typedef enum logic [1:0] {
    FILT_OFF = 2'h0,
    FILT_1US = 2'h1,
    FILT_2MS = 2'h2,
    FILT_5S = 2'h3
  } filter_sel_t;

  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_CHARGE = 2'h1,
    WK_DONE = 2'h3
  } wakeup_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage : charger_ctrl_pkg

// ---- verilog/tick_timer.sv ----
// Purpose: Counts time base ticks while run is high and flags expiry
// Assumes: tick is a one-cycle enable from a free-running divider
// Notes: Dropping run restarts the count; first tick may be up to one period short

`timescale 1ns/1ps
`default_nettype none

module tick_timer #(
  parameter int unsigned W = 21
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic expired
);

  logic [W-1:0] cnt_ff;

  initial begin
    if (W < 2) begin
      $error("tick_timer width too small");
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt_ff <= '0;
    end else if (tick && cnt_ff < limit) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign expired = run && (cnt_ff >= limit);

endmodule : tick_timer

`default_nettype wire

// ---- tb/charger_ctrl_assertions.sv ----
// Purpose: Port checker for the charger option low byte control block
// Assumes: Parameters equal those of the bound instance
// Notes: Bind statement sits after endmodule
`timescale 1ns/1ps
`default_nettype none
module charger_ctrl_checker
  import charger_ctrl_pkg::*;
#(
  parameter int unsigned DISCHARGE_TICKS = 4,
  parameter int unsigned WAKEUP_TICKS = 5,
  parameter int unsigned US_CYCLES = 4,
  parameter int unsigned MS_US = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic battery_below_min,
  input wire logic converter_enable,
  input wire logic supply_good_source,
  input wire logic comparator_output,
  input wire logic comparator_threshold_select,
  input wire logic input_side_switch_on,
  input wire logic output_side_switch_on,
  input wire logic supply_good_indicator,
  input wire logic battery_sense_negative_discharge,
  input wire logic wakeup_charge_128ma
);
  localparam int unsigned MS_CYC = MS_US * US_CYCLES;
  int unsigned dis_cnt_ff;
  int unsigned wk_cnt_ff;
  wire logic ctrl_wr = reg_req.wr && reg_req.addr == CTRL_B_OFFSET;
  // Host rewrites restart the count, so they must not trip the bound
  always_ff @(posedge clk) begin
    dis_cnt_ff <= (srst || !battery_sense_negative_discharge || ctrl_wr) ? 0 : dis_cnt_ff + 1;
  end
  always_ff @(posedge clk) begin
    wk_cnt_ff <= (srst || !wakeup_charge_128ma || ctrl_wr) ? 0 : wk_cnt_ff + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence thr_wr(b);
    ctrl_wr && reg_req.wdata[7] == b ##1 !ctrl_wr;
  endsequence
  sequence bat_ok;
    !battery_below_min [*5];
  endsequence
  reset_state_a: assert property ($fell(srst) |-> reg_rdata == 16'h0 && comparator_output
    && !battery_sense_negative_discharge && !wakeup_charge_128ma) else $error("reset state");
  read_idle_a: assert property (!reg_req.rd |=> reg_rdata == 16'h0) else $error("idle rdata");
  unmapped_a: assert property (reg_req.rd && reg_req.addr != CTRL_B_OFFSET |=> reg_rdata == 16'h0)
    else $error("unmapped read");
  thr_set_a: assert property (thr_wr(1'b1) |=> comparator_threshold_select) else $error("thr");
  thr_clr_a: assert property (thr_wr(1'b0) |=> !comparator_threshold_select) else $error("thr");
  switch_gate_a: assert property (input_side_switch_on |-> $past(converter_enable))
    else $error("switch without enable");
  switch_pair_a: assert property (input_side_switch_on == output_side_switch_on)
    else $error("switches differ");
  supply_gate_a: assert property (supply_good_indicator |-> $past(supply_good_source))
    else $error("supply good without source");
  discharge_len_a: assert property (dis_cnt_ff <= (DISCHARGE_TICKS + 1) * MS_CYC + 2)
    else $error("discharge too long");
  wakeup_stop_a: assert property (bat_ok |-> !wakeup_charge_128ma) else $error("wake on");
  wakeup_len_a: assert property (wk_cnt_ff <= (WAKEUP_TICKS + 1) * MS_CYC + 2)
    else $error("wakeup too long");
endmodule : charger_ctrl_checker
bind charger_option_low_byte_ctrl charger_ctrl_checker #(.DISCHARGE_TICKS(DISCHARGE_TICKS),
  .WAKEUP_TICKS(WAKEUP_TICKS), .US_CYCLES(US_CYCLES), .MS_US(MS_US)) chk (.clk(clk),
  .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .battery_below_min(battery_below_min),
  .converter_enable(converter_enable), .supply_good_source(supply_good_source),
  .comparator_output(comparator_output),
  .comparator_threshold_select(comparator_threshold_select),
  .input_side_switch_on(input_side_switch_on), .output_side_switch_on(output_side_switch_on),
  .supply_good_indicator(supply_good_indicator),
  .battery_sense_negative_discharge(battery_sense_negative_discharge),
  .wakeup_charge_128ma(wakeup_charge_128ma));
`default_nettype wire

// ---- tb/smbus_host_model.sv ----
// Purpose: Host side of the decoded register port
// Assumes: Bus engine already turned serial frames into strobes
// Notes: One access per call, strobe held for one edge
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
  import charger_ctrl_pkg::*;
(
  input wire logic clk,
  output var reg_req_t reg_req,
  input wire logic [15:0] reg_rdata
);
  initial reg_req = '0;
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] rd);
    @(posedge clk);
    reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    // Read word stands only in the cycle after the strobe edge
    @(negedge clk);
    rd = reg_rdata;
  endtask : access
endmodule : smbus_host_model
`default_nettype wire

// ---- tb/charger_option_low_byte_ctrl_test.sv ----
// Purpose: Self-checking bench for the charger option low byte control block
// Assumes: Shortened timers, 1 ms is 12 cycles
// Notes: Table loop for comparator modes, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
module charger_option_low_byte_ctrl_test;
  import charger_ctrl_pkg::*;
  typedef struct packed {logic [15:0] ctrl; logic above; logic exp_out;} row_t;
  logic clk, srst, above, bat_low, conv_en, sg_src;
  logic cmp_out, thr, sw_in, sw_out, sg, dis, wk;
  logic [15:0] rdata, rd;
  reg_req_t req;
  int fail_count, n_checks;
  row_t rows [8] = '{'{16'h0210, 1'b1, 1'b0}, '{16'h0200, 1'b1, 1'b1},
    '{16'h0210, 1'b0, 1'b1}, '{16'h0250, 1'b0, 1'b0}, '{16'h0250, 1'b1, 1'b1},
    '{16'h0220, 1'b1, 1'b0}, '{16'h0230, 1'b1, 1'b0}, '{16'h0290, 1'b0, 1'b1}};
  smbus_host_model host (.clk(clk), .reg_req(req), .reg_rdata(rdata));
  charger_option_low_byte_ctrl #(.DEG_LONG_TICKS(3), .DISCHARGE_TICKS(4), .WAKEUP_TICKS(5),
    .US_CYCLES(4), .MS_US(3)) dut (.clk(clk), .srst(srst), .reg_req(req), .reg_rdata(rdata),
    .comparator_input_above(above), .battery_below_min(bat_low), .converter_enable(conv_en),
    .supply_good_source(sg_src), .comparator_output(cmp_out),
    .comparator_threshold_select(thr), .input_side_switch_on(sw_in),
    .output_side_switch_on(sw_out), .supply_good_indicator(sg),
    .battery_sense_negative_discharge(dis), .wakeup_charge_128ma(wk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.access(1'b1, a, d, rd);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    host.access(1'b0, a, 16'h0, rd);
    check("ctrl_word", rd, e);
  endtask : rdchk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    srst = 1'b1; above = 1'b0; bat_low = 1'b0; conv_en = 1'b1; sg_src = 1'b1;
    cyc(16);
    srst <= 1'b0;
    cyc(3);
    check("cmp_out", cmp_out, 1'b1);
    rdchk(8'h30, 16'h0211);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(8'h30, rows[i].ctrl);
      @(posedge clk) above <= rows[i].above;
      cyc(60);
      check("cmp_out", cmp_out, rows[i].exp_out);
      check("thr_sel", thr, rows[i].ctrl[7]);
      check("switch", sw_in, 1'b1);
      rdchk(8'h30, rows[i].ctrl);
      $display("row %0d done", i);
    end
    // ----------------------------------------
    // Deglitch only on the falling edge
    // ----------------------------------------
    wr(8'h30, 16'h0220);
    @(posedge clk) above <= 1'b1;
    cyc(12);
    check("cmp_hold", cmp_out, 1'b1);
    cyc(30);
    check("cmp_fall", cmp_out, 1'b0);
    @(posedge clk) above <= 1'b0;
    cyc(4);
    check("cmp_rise", cmp_out, 1'b1);
    $display("deglitch test done");
    wr(8'h30, 16'h0218);
    cyc(3);
    check("sw_on", sw_in, 1'b1);
    @(posedge clk) above <= 1'b1;
    cyc(20);
    check("sw_in", sw_in, 1'b0);
    check("sw_out", sw_out, 1'b0);
    check("sg", sg, 1'b0);
    @(posedge clk) above <= 1'b0;
    cyc(10);
    check("sw_latch", sw_in, 1'b0);
    wr(8'h30, 16'h0210);
    cyc(3);
    check("sw_back", sw_in, 1'b1);
    check("sg_back", sg, 1'b1);
    wr(8'h31, 16'hFFFF);
    rdchk(8'h31, 16'h0000);
    rdchk(8'h30, 16'h0210);
    $display("path off test done");
    @(posedge clk) conv_en <= 1'b0;
    sg_src <= 1'b0;
    cyc(2);
    check("sw_gate", sw_in, 1'b0);
    check("sw_out_gate", sw_out, 1'b0);
    check("sg_gate", sg, 1'b0);
    conv_en <= 1'b1;
    sg_src <= 1'b1;
    cyc(2);
    check("sw_ungate", sw_in, 1'b1);
    check("sg_ungate", sg, 1'b1);
    $display("source gating test done");
    wr(8'h30, 16'h0212);
    cyc(2);
    check("dis_on", dis, 1'b1);
    cyc(70);
    check("dis_off", dis, 1'b0);
    rdchk(8'h30, 16'h0210);
    $display("discharge test done");
    @(posedge clk) bat_low <= 1'b1;
    wr(8'h30, 16'h0211);
    cyc(6);
    check("wk_on", wk, 1'b1);
    @(posedge clk) bat_low <= 1'b0;
    cyc(8);
    check("wk_stop", wk, 1'b0);
    rdchk(8'h30, 16'h0210);
    @(posedge clk) bat_low <= 1'b1;
    wr(8'h30, 16'h0211);
    cyc(100);
    check("wk_timeout", wk, 1'b0);
    rdchk(8'h30, 16'h0211);
    $display("wakeup test done");
    finish_test();
  end
endmodule : charger_option_low_byte_ctrl_test
`default_nettype wire
